// file: verilog/dso_status_out.sv
// Purpose: drive status and response outputs toward the drive controller
// Assumes: pins asynchronous; classic wishbone slave for control and status
// Notes: read bit clock is sampled, its rising edge strobes read data
// Summary of operation
// - latch offset ready on go with offset mode, servo ready, no reset, no clear
// - drive positioning unfinished while heads are off cylinder
// - issue index pulse at pack index, aligned to the sector clock
// - assert index error on index fault while write command is active
// - file ready when offset ready is false or servo is ready
// - OR eight unsafe indicators into three summary outputs
// - any unsafe indicator drives overall unsafe and the unsafe lamp
// - set on-line latch with plug present, servo data sensed and heads loaded or recalibrate active
// - reset on-line on plug removal or servo data loss outside recalibrate
// - forward separated NRZ read data onto the bidirectional bus
// - heads loaded becomes servo data, read only becomes write protect
// - reference clocks and read bit clock become logic-level outputs
// - read data is NRZ, strobed by the read bit clock
// - release unsafe clear about one second after supplies turn healthy
// - supply faults of 80 us or less leave unsafe clear unchanged
// - supply faults of 500 us or longer assert unsafe clear
// - fault sense healthy only when all supplies are in tolerance
//
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module dso_status_out #(
  parameter int unsigned IGNORE_CYC = dso_pkg::FAULT_IGNORE_CYC,
  parameter int unsigned ASSERT_CYC = dso_pkg::FAULT_ASSERT_CYC,
  parameter int unsigned RELEASE_CYC = dso_pkg::RELEASE_CYC
) (
  // system
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  // drive pins
  input wire dso_pkg::dso_pins_t pins,
  // controller responses
  output logic offset_ready,
  output logic positioning_unfinished,
  output logic index_pulse,
  output logic index_error,
  output logic file_ready,
  output logic servo_data_resp,
  output logic write_protect_resp,
  output logic on_line,
  output logic [dso_pkg::NUM_SUMMARY-1:0] unsafe_summary,
  // unsafe to maintenance tool and lamp
  output logic unsafe,
  output logic unsafe_lamp,
  // clocks and read data
  output logic read_strobe,
  output logic reference_clock_out,
  output logic read_data_o,
  output logic read_data_oe,
  // power monitor
  output logic supply_fault_sense,
  output logic unsafe_clear
);
  dso_pkg::dso_pins_t s;
  logic idx_q;
  logic sec_q;
  logic rbc_q;
  logic index_pend;
  logic on_line_q;
  logic [1:0] ctrl;
  logic [dso_pkg::NUM_EV-1:0] irq_stat;
  logic [dso_pkg::NUM_EV-1:0] irq_mask;
  logic [dso_pkg::NUM_EV-1:0] ev;
  logic [31:0] status_word;
  logic idx_rise;
  logic sec_rise;
  logic rbc_rise;
  logic bus_req;
  logic wr_lane;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  dso_sync #(.W($bits(dso_pkg::dso_pins_t))) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .d(pins),
    .q(s)
  );

  dso_power_mon #(
    .IGNORE_CYC(IGNORE_CYC),
    .ASSERT_CYC(ASSERT_CYC),
    .RELEASE_CYC(RELEASE_CYC)
  ) u_pmon (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .supply_in_tol(s.supply_in_tol),
    .supply_over_limit(s.supply_over_limit),
    .supply_fault_sense(supply_fault_sense),
    .unsafe_clear(unsafe_clear)
  );

  assign idx_rise = s.pack_index & ~idx_q;
  assign sec_rise = s.sector_clock & ~sec_q;
  assign rbc_rise = s.read_bit_clock & ~rbc_q;
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_lane = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

  // edge history of sampled pins
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      idx_q <= 1'b0;
      sec_q <= 1'b0;
      rbc_q <= 1'b0;
      on_line_q <= 1'b0;
    end
    else if (ce)
    begin
      idx_q <= s.pack_index;
      sec_q <= s.sector_clock;
      rbc_q <= s.read_bit_clock;
      on_line_q <= on_line;
    end
  end

  // offset ready latch
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      offset_ready <= 1'b0;
    else if (ce)
    begin
      if (s.offset_reset || unsafe_clear)
        offset_ready <= 1'b0;
      else if (s.seek_offset_go && s.offset_mode && s.servo_ready)
        offset_ready <= 1'b1;
    end
  end

  // direct status responses
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      positioning_unfinished <= 1'b0;
      index_error <= 1'b0;
      file_ready <= 1'b0;
      servo_data_resp <= 1'b0;
      write_protect_resp <= 1'b0;
    end
    else if (ce)
    begin
      positioning_unfinished <= s.off_cylinder;
      index_error <= s.index_fault & s.write_cmd;
      file_ready <= ~offset_ready | s.servo_ready;
      servo_data_resp <= s.heads_loaded;
      write_protect_resp <= s.read_only;
    end
  end

  // index held until the next sector clock edge
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      index_pend <= 1'b0;
      index_pulse <= 1'b0;
    end
    else if (ce)
    begin
      index_pend <= (index_pend | idx_rise) & ~sec_rise;
      index_pulse <= (index_pend | idx_rise) & sec_rise;
    end
  end

  // unsafe summaries and lamp
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      unsafe_summary <= '0;
      unsafe <= 1'b0;
      unsafe_lamp <= 1'b0;
    end
    else if (ce)
    begin
      unsafe_summary[0] <= |s.unsafe_ind[2:0];
      unsafe_summary[1] <= |s.unsafe_ind[5:3];
      unsafe_summary[2] <= |s.unsafe_ind[7:6];
      unsafe <= |s.unsafe_ind;
      unsafe_lamp <= (|s.unsafe_ind) | ctrl[dso_pkg::CTRL_LAMP_TEST];
    end
  end

  // on-line latch
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      on_line <= 1'b0;
    else if (ce)
    begin
      if (!s.logical_address_plug || (!s.servo_data_sensed && !s.recal_active))
        on_line <= 1'b0;
      else if (s.servo_data_sensed && (s.heads_loaded || s.recal_active))
        on_line <= 1'b1;
    end
  end

  // clocks and read data
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      read_strobe <= 1'b0;
      reference_clock_out <= 1'b0;
      read_data_o <= 1'b0;
      read_data_oe <= 1'b0;
    end
    else if (ce)
    begin
      read_strobe <= s.read_bit_clock;
      reference_clock_out <= s.reference_oscillator;
      read_data_oe <= ctrl[dso_pkg::CTRL_READ_OE];
      if (rbc_rise)
        read_data_o <= s.separated_nrz_read;
    end
  end

  // event sources
  always_comb
  begin
    ev = '0;
    ev[dso_pkg::EV_INDEX] = index_pulse;
    ev[dso_pkg::EV_INDEX_ERR] = index_error;
    ev[dso_pkg::EV_POS_UNFIN] = positioning_unfinished;
    ev[dso_pkg::EV_UNSAFE] = unsafe;
    ev[dso_pkg::EV_VCLEAR] = unsafe_clear;
    ev[dso_pkg::EV_ON_LINE] = on_line ^ on_line_q;
  end

  // sticky status, set wins over write-one clear
  genvar gi;
  generate
    for (gi = 0; gi < dso_pkg::NUM_EV; gi++)
    begin : g_irq
      always_ff @(posedge clock)
      begin
        if (!rst_n)
          irq_stat[gi] <= 1'b0;
        else if (ce)
          irq_stat[gi] <= ev[gi] | (irq_stat[gi] & ~(wr_lane & hit(wb_adr_i, dso_pkg::ADR_IRQ_STAT)
            & wb_dat_i[gi]));
      end
    end
  endgenerate

  // control and mask registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ctrl <= dso_pkg::CTRL_RESET;
      irq_mask <= dso_pkg::IRQ_RESET;
    end
    else if (ce && wr_lane)
    begin
      if (hit(wb_adr_i, dso_pkg::ADR_CTRL))
        ctrl <= wb_dat_i[1:0];
      else if (hit(wb_adr_i, dso_pkg::ADR_IRQ_MASK))
        irq_mask <= wb_dat_i[dso_pkg::NUM_EV-1:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else if (ce)
      irq <= |(irq_stat & irq_mask);
  end

  always_comb
  begin
    status_word = '0;
    status_word[dso_pkg::ST_OFFSET_READY] = offset_ready;
    status_word[dso_pkg::ST_POS_UNFIN] = positioning_unfinished;
    status_word[dso_pkg::ST_FILE_READY] = file_ready;
    status_word[dso_pkg::ST_ON_LINE] = on_line;
    status_word[dso_pkg::ST_UNSAFE] = unsafe;
    status_word[dso_pkg::ST_VCLEAR] = unsafe_clear;
    status_word[dso_pkg::ST_SUPPLY_FAULT] = supply_fault_sense;
    status_word[dso_pkg::ST_INDEX_ERR] = index_error;
    status_word[dso_pkg::ST_BUS_IN] = s.bus_data_in;
    status_word[dso_pkg::ST_SUMMARY +: dso_pkg::NUM_SUMMARY] = unsafe_summary;
  end

  // bus answer one cycle after the request
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else if (ce)
    begin
      wb_ack_o <= bus_req;
      if (!bus_req || wb_we_i)
        wb_dat_o <= '0;
      else if (hit(wb_adr_i, dso_pkg::ADR_CTRL))
        wb_dat_o <= {30'h0, ctrl};
      else if (hit(wb_adr_i, dso_pkg::ADR_STATUS))
        wb_dat_o <= status_word;
      else if (hit(wb_adr_i, dso_pkg::ADR_IRQ_STAT))
        wb_dat_o <= {26'h0, irq_stat};
      else if (hit(wb_adr_i, dso_pkg::ADR_IRQ_MASK))
        wb_dat_o <= {26'h0, irq_mask};
      else
        wb_dat_o <= '0;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_offset_set: assert property (ce && s.seek_offset_go && s.offset_mode && s.servo_ready
    && !s.offset_reset && !unsafe_clear |=> offset_ready)
    else $error("offset ready not latched");
  a_offset_clear: assert property (ce && (s.offset_reset || unsafe_clear) |=> !offset_ready)
    else $error("offset ready not cleared");
  a_seek_unfinished: assert property (ce && s.off_cylinder |=> positioning_unfinished)
    else $error("off cylinder not reported");
  a_index_aligned: assert property (index_pulse |-> $past(sec_rise))
    else $error("index pulse off sector clock");
  a_index_error: assert property (ce && s.index_fault && s.write_cmd |=> index_error)
    else $error("index error missing");
  a_file_ready: assert property (ce && (!offset_ready || s.servo_ready) |=> file_ready)
    else $error("file ready missing");
  a_unsafe_or: assert property (ce && |s.unsafe_ind |=> unsafe && unsafe_lamp && |unsafe_summary)
    else $error("unsafe not raised");
  a_online_drop: assert property (ce && !s.logical_address_plug |=> !on_line)
    else $error("on line kept without plug");
  a_read_strobe: assert property (ce && rbc_rise |=> read_data_o == $past(s.separated_nrz_read))
    else $error("read data not strobed");
  a_wb_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  c_offset_ready: cover property (!offset_ready ##1 offset_ready);
  c_index_pulse: cover property (index_pulse);
  c_on_line: cover property (!on_line ##1 on_line);
  c_irq: cover property (!irq ##1 irq);
endmodule

// file: verilog/dso_pkg.sv
// Purpose: shared constants and types of the drive status output block
// Assumes: 25 MHz system clock
// Notes: counts derive from times and the clock rate
package dso_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  // glitch filter and turn-on delay times
  localparam int unsigned FAULT_IGNORE_US = 80;
  localparam int unsigned FAULT_ASSERT_US = 500;
  localparam int unsigned RELEASE_MS = 1000;
  localparam int unsigned FAULT_IGNORE_CYC = FAULT_IGNORE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FAULT_ASSERT_CYC = FAULT_ASSERT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RELEASE_CYC = RELEASE_MS * (CLK_HZ / 1000);
  localparam int unsigned NUM_SUPPLY = 5;
  localparam int unsigned NUM_UNSAFE = 8;
  localparam int unsigned NUM_SUMMARY = 3;
  // register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h0c;
  // control bits
  localparam int unsigned CTRL_LAMP_TEST = 0;
  localparam int unsigned CTRL_READ_OE = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  // status bits
  localparam int unsigned ST_OFFSET_READY = 0;
  localparam int unsigned ST_POS_UNFIN = 1;
  localparam int unsigned ST_FILE_READY = 2;
  localparam int unsigned ST_ON_LINE = 3;
  localparam int unsigned ST_UNSAFE = 4;
  localparam int unsigned ST_VCLEAR = 5;
  localparam int unsigned ST_SUPPLY_FAULT = 6;
  localparam int unsigned ST_INDEX_ERR = 7;
  localparam int unsigned ST_BUS_IN = 8;
  localparam int unsigned ST_SUMMARY = 16;
  // interrupt event bits
  localparam int unsigned EV_INDEX = 0;
  localparam int unsigned EV_INDEX_ERR = 1;
  localparam int unsigned EV_POS_UNFIN = 2;
  localparam int unsigned EV_UNSAFE = 3;
  localparam int unsigned EV_VCLEAR = 4;
  localparam int unsigned EV_ON_LINE = 5;
  localparam int unsigned NUM_EV = 6;
  localparam logic [5:0] IRQ_RESET = 6'h00;

  typedef struct packed {
    logic seek_offset_go;
    logic offset_mode;
    logic offset_reset;
    logic write_cmd;
    logic servo_ready;
    logic off_cylinder;
    logic pack_index;
    logic sector_clock;
    logic index_fault;
    logic logical_address_plug;
    logic servo_data_sensed;
    logic recal_active;
    logic heads_loaded;
    logic read_only;
    logic read_bit_clock;
    logic separated_nrz_read;
    logic reference_oscillator;
    logic bus_data_in;
    logic [7:0] unsafe_ind;
    logic [4:0] supply_in_tol;
    logic [4:0] supply_over_limit;
  } dso_pins_t;
endpackage

// file: verilog/dso_sync.sv
// Purpose: two-stage synchroniser for a group of pins
// Assumes: inputs asynchronous to clock
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module dso_sync #(
  parameter int W = 1
) (
  // system
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q <= '0;
    end
    else if (ce)
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// file: verilog/dso_power_mon.sv
// Purpose: power monitor qualifier producing the unsafe-voltage clear
// Assumes: supply flags already synchronised
// Notes: clear is high out of reset until supplies prove good
`timescale 1ns/1ps
module dso_power_mon #(
  parameter int unsigned IGNORE_CYC = dso_pkg::FAULT_IGNORE_CYC,
  parameter int unsigned ASSERT_CYC = dso_pkg::FAULT_ASSERT_CYC,
  parameter int unsigned RELEASE_CYC = dso_pkg::RELEASE_CYC
) (
  // system
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // supplies
  input wire logic [dso_pkg::NUM_SUPPLY-1:0] supply_in_tol,
  input wire logic [dso_pkg::NUM_SUPPLY-1:0] supply_over_limit,
  // results
  output logic supply_fault_sense,
  output logic unsafe_clear
);
  localparam int FW = $clog2(ASSERT_CYC + 1);
  localparam int RW = $clog2(RELEASE_CYC + 1);
  logic [FW-1:0] fault_cnt;
  logic [RW-1:0] ok_cnt;

  // failing on any limit, healthy only with all in tolerance
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      supply_fault_sense <= 1'b1;
    else if (ce)
    begin
      if (|supply_over_limit)
        supply_fault_sense <= 1'b1;
      else if (&supply_in_tol)
        supply_fault_sense <= 1'b0;
    end
  end

  // fault duration, restarts on every healthy cycle
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      fault_cnt <= '0;
    else if (ce)
    begin
      if (!supply_fault_sense)
        fault_cnt <= '0;
      else if (fault_cnt != FW'(ASSERT_CYC))
        fault_cnt <= fault_cnt + 1'b1;
    end
  end

  // healthy duration while clear is held
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      ok_cnt <= '0;
    else if (ce)
    begin
      if (supply_fault_sense || !unsafe_clear)
        ok_cnt <= '0;
      else
        ok_cnt <= ok_cnt + 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      unsafe_clear <= 1'b1;
    else if (ce)
    begin
      if (supply_fault_sense && fault_cnt == FW'(ASSERT_CYC - 1))
        unsafe_clear <= 1'b1;
      else if (!supply_fault_sense && unsafe_clear && ok_cnt == RW'(RELEASE_CYC - 1))
        unsafe_clear <= 1'b0;
    end
  end

  default clocking pm_cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_fault_sense_set: assert property (ce && |supply_over_limit |=> supply_fault_sense)
    else $error("supply fault not reported");
  a_glitch_ignored: assert property (ce && !unsafe_clear && fault_cnt < FW'(IGNORE_CYC) |=> !unsafe_clear)
    else $error("short fault changed clear");
  a_clear_asserts: assert property (ce && supply_fault_sense && fault_cnt == FW'(ASSERT_CYC - 1)
    |=> unsafe_clear)
    else $error("long fault did not assert clear");
  a_clear_release: assert property (ce && unsafe_clear && !supply_fault_sense
    && ok_cnt == RW'(RELEASE_CYC - 1) |=> !unsafe_clear)
    else $error("clear not released after delay");
  a_no_early_release: assert property (unsafe_clear && ok_cnt < RW'(RELEASE_CYC - 1) |=> unsafe_clear)
    else $error("clear released early");
  c_clear_released: cover property (unsafe_clear ##1 !unsafe_clear);
endmodule

// file: test/dso_ctl_model.sv
// Purpose: far-side model of the read data link
// Assumes: strobe and data come back from the block
// Notes: link clock stands still low outside a frame
`timescale 1ns/1ps
module dso_ctl_model (
  // frame control
  input wire logic go,
  input wire logic [7:0] pattern,
  // link toward the block
  output logic read_bit_clock,
  output logic separated_nrz_read,
  // responses from the block
  input wire logic read_strobe,
  input wire logic read_data_o,
  output logic [7:0] captured
);
  initial
  begin
    read_bit_clock = 1'b0;
    separated_nrz_read = 1'b0;
    captured = 8'h00;
  end
  // one bit per rise, data moves on the fall
  always @(posedge go)
  begin
    #7;
    for (int i = 7; i >= 0; i--)
    begin
      separated_nrz_read = pattern[i];
      #160 read_bit_clock = 1'b1;
      #160 read_bit_clock = 1'b0;
    end
    separated_nrz_read = ~separated_nrz_read;
  end
  // controller takes each bit as the strobe falls
  always @(negedge read_strobe)
    captured <= {captured[6:0], read_data_o};
endmodule

// file: test/dso_status_out_tb.sv
// Purpose: self-checking bench of the status output block
// Assumes: short power monitor counts
// Notes: pins change at rising edges, checks after the sync delay
`timescale 1ns/1ps
module dso_status_out_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic ce = 1'b1;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, irq, offset_ready, positioning_unfinished, index_pulse, index_error;
  logic file_ready, servo_data_resp, write_protect_resp, on_line, unsafe, unsafe_lamp;
  logic read_strobe, reference_clock_out, read_data_o, read_data_oe, supply_fault_sense, unsafe_clear;
  logic [2:0] unsafe_summary;
  dso_pkg::dso_pins_t p = '0;
  dso_pkg::dso_pins_t pins;
  logic lbc, nrz, go = 1'b0;
  logic [7:0] cap;
  logic [31:0] d;
  int err_total = 0;
  int checks_done = 0;
  int pulses = 0;
  int cyc = 0;
  always #20 clock = ~clock;
  always_comb
  begin
    pins = p;
    pins.read_bit_clock = lbc;
    pins.separated_nrz_read = nrz;
  end
  dso_status_out #(.IGNORE_CYC(4), .ASSERT_CYC(10), .RELEASE_CYC(50)) dso_status_out_inst (
    .clock(clock), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .pins(pins), .offset_ready(offset_ready),
    .positioning_unfinished(positioning_unfinished), .index_pulse(index_pulse),
    .index_error(index_error), .file_ready(file_ready), .servo_data_resp(servo_data_resp),
    .write_protect_resp(write_protect_resp), .on_line(on_line), .unsafe_summary(unsafe_summary),
    .unsafe(unsafe), .unsafe_lamp(unsafe_lamp), .read_strobe(read_strobe),
    .reference_clock_out(reference_clock_out), .read_data_o(read_data_o),
    .read_data_oe(read_data_oe), .supply_fault_sense(supply_fault_sense), .unsafe_clear(unsafe_clear));
  dso_ctl_model dso_ctl_model_inst (.go(go), .pattern(8'ha5), .read_bit_clock(lbc),
    .separated_nrz_read(nrz), .read_strobe(read_strobe), .read_data_o(read_data_o), .captured(cap));
  always @(posedge clock)
  begin
    cyc++;
    if (index_pulse === 1'b1)
      pulses++;
    if (cyc == 20000)
    begin
      err_total++;
      wrap_up;
    end
  end
  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    do
    begin
      @(posedge clock);
    end while (wb_ack_o !== 1'b1);
    d = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    w(20);
    rst_n <= 1'b1;
    w(2);
    bus(0, dso_pkg::ADR_CTRL, 0);
    chk(d, 32'h2);
    bus(0, dso_pkg::ADR_IRQ_MASK, 0);
    chk(d, 32'h0);
    bus(0, 8'h10, 0);
    chk(d, 32'h0);
    p.seek_offset_go <= 1'b1;
    p.offset_mode <= 1'b1;
    p.servo_ready <= 1'b1;
    w(5);
    chk(offset_ready, 0);
    p.seek_offset_go <= 1'b0;
    p.supply_in_tol <= 5'h1f;
    w(5);
    chk(supply_fault_sense, 0);
    w(20);
    chk(unsafe_clear, 1);
    w(60);
    chk(unsafe_clear, 0);
    p.supply_over_limit <= 5'h04;
    w(4);
    p.supply_over_limit <= 5'h00;
    w(20);
    chk(unsafe_clear, 0);
    note("power");
    p.seek_offset_go <= 1'b1;
    w(4);
    p.seek_offset_go <= 1'b0;
    chk(offset_ready, 1);
    chk(file_ready, 1);
    p.servo_ready <= 1'b0;
    w(4);
    chk(file_ready, 0);
    p.offset_reset <= 1'b1;
    w(5);
    chk(offset_ready, 0);
    chk(file_ready, 1);
    p.offset_reset <= 1'b0;
    p.servo_ready <= 1'b1;
    p.seek_offset_go <= 1'b1;
    w(4);
    p.seek_offset_go <= 1'b0;
    p.supply_over_limit <= 5'h01;
    w(16);
    chk(unsafe_clear, 1);
    chk(offset_ready, 0);
    p.supply_over_limit <= 5'h00;
    w(90);
    note("offset");
    p.off_cylinder <= 1'b1;
    p.index_fault <= 1'b1;
    p.heads_loaded <= 1'b1;
    p.read_only <= 1'b1;
    w(4);
    chk(positioning_unfinished, 1);
    chk(index_error, 0);
    chk({servo_data_resp, write_protect_resp}, 2'h3);
    p.write_cmd <= 1'b1;
    p.off_cylinder <= 1'b0;
    p.heads_loaded <= 1'b0;
    w(4);
    chk(index_error, 1);
    chk({positioning_unfinished, servo_data_resp}, 2'h0);
    p.write_cmd <= 1'b0;
    p.index_fault <= 1'b0;
    pulses = 0;
    p.pack_index <= 1'b1;
    w(6);
    chk(pulses, 0);
    p.sector_clock <= 1'b1;
    w(6);
    chk(pulses, 1);
    p.pack_index <= 1'b0;
    p.sector_clock <= 1'b0;
    w(4);
    p.sector_clock <= 1'b1;
    w(6);
    chk(pulses, 1);
    note("index");
    for (int i = 0; i < 8; i++)
    begin
      p.unsafe_ind <= 8'h01 << i;
      w(4);
      chk({unsafe, unsafe_lamp, unsafe_summary}, {2'h3, 3'h1 << ((i < 3) ? 0 : (i < 6) ? 1 : 2)});
    end
    p.unsafe_ind <= 8'h00;
    bus(1, dso_pkg::ADR_CTRL, 32'h1);
    w(3);
    chk({unsafe, unsafe_lamp, read_data_oe}, 3'h2);
    bus(1, dso_pkg::ADR_CTRL, 32'h2);
    wb_sel_i <= 4'he;
    bus(1, dso_pkg::ADR_CTRL, 32'h1);
    wb_sel_i <= 4'hf;
    bus(0, dso_pkg::ADR_CTRL, 0);
    chk(d, 32'h2);
    note("unsafe");
    p.logical_address_plug <= 1'b1;
    p.servo_data_sensed <= 1'b1;
    p.heads_loaded <= 1'b1;
    w(4);
    chk(on_line, 1);
    p.recal_active <= 1'b1;
    p.servo_data_sensed <= 1'b0;
    w(4);
    chk(on_line, 1);
    p.recal_active <= 1'b0;
    w(4);
    chk(on_line, 0);
    p.servo_data_sensed <= 1'b1;
    w(4);
    chk(on_line, 1);
    p.logical_address_plug <= 1'b0;
    w(4);
    chk(on_line, 0);
    note("on_line");
    go <= 1'b1;
    w(80);
    chk(cap, 8'ha5);
    chk(read_data_oe, 1);
    p.reference_oscillator <= 1'b1;
    w(4);
    chk(reference_clock_out, 1);
    note("read");
    ce <= 1'b0;
    p.off_cylinder <= 1'b1;
    w(6);
    chk(positioning_unfinished, 0);
    ce <= 1'b1;
    w(4);
    chk(positioning_unfinished, 1);
    p.off_cylinder <= 1'b0;
    p.bus_data_in <= 1'b1;
    w(4);
    note("enable");
    bus(1, dso_pkg::ADR_IRQ_STAT, 32'h3f);
    bus(1, dso_pkg::ADR_IRQ_MASK, 32'h4);
    w(2);
    chk(irq, 0);
    p.off_cylinder <= 1'b1;
    w(6);
    chk(irq, 1);
    bus(1, dso_pkg::ADR_IRQ_MASK, 32'h0);
    w(2);
    chk(irq, 0);
    p.off_cylinder <= 1'b0;
    w(4);
    bus(1, dso_pkg::ADR_IRQ_STAT, 32'h4);
    bus(0, dso_pkg::ADR_IRQ_STAT, 0);
    chk(d & 32'h4, 32'h0);
    bus(0, dso_pkg::ADR_STATUS, 0);
    chk(d, 32'h104);
    note("irq");
    wrap_up;
  end
endmodule
